// ===== acdr_consts.svh
// Constants of the sensor output data register bank: addresses, field
// positions, widths and reset values.
// Assumes inclusion by its bare name from the package alone.
`ifndef ACDR_CONSTS_SVH
`define ACDR_CONSTS_SVH

// -----------------------------------------------------------------------------
// Register addresses
// -----------------------------------------------------------------------------
`define ACDR_ADDR_STATUS_A   8'h00
`define ACDR_ADDR_X_HI8      8'h01
`define ACDR_ADDR_Y_HI8      8'h02
`define ACDR_ADDR_Z_HI8      8'h03
`define ACDR_ADDR_STATUS_B   8'h04
`define ACDR_ADDR_X_LO       8'h05
`define ACDR_ADDR_X_HI12     8'h06
`define ACDR_ADDR_Y_LO       8'h07
`define ACDR_ADDR_Y_HI12     8'h08
`define ACDR_ADDR_Z_LO       8'h09
`define ACDR_ADDR_Z_HI12     8'h0A
`define ACDR_ADDR_STATUS_C   8'h0B
`define ACDR_ADDR_X_DELTA    8'h0C
`define ACDR_ADDR_Y_DELTA    8'h0D
`define ACDR_ADDR_Z_DELTA    8'h0E

// -----------------------------------------------------------------------------
// Field layout and reset values
// -----------------------------------------------------------------------------
`define ACDR_SAMPLE_W        12
`define ACDR_HI_MSB          11
`define ACDR_HI_LSB          4
`define ACDR_LO_MSB          3
`define ACDR_ZERO_BYTE       8'h00
`define ACDR_ZERO_NIBBLE     4'h0
`define ACDR_RST_ADDR        8'h00
`define ACDR_ADDR_STEP       8'h01
`define ACDR_BYTES_PER_8BIT  3'h3
`define ACDR_BYTES_PER_12BIT 3'h6
`define ACDR_FIFO_DEPTH      32
`define ACDR_FIFO_CNT_W      6

`endif

// ===== acdr_pkg.sv
// Types shared by the sensor output data register bank.
// Assumes the constants header sits in the same folder.
`default_nettype none

package acdr_pkg;

	`include "acdr_consts.svh"

	// -------------------------------------------------------------------------
	// Carriers
	// -------------------------------------------------------------------------
	// One three-axis 12-bit two's complement sample.
	typedef struct packed {
		logic [`ACDR_SAMPLE_W-1:0] z;
		logic [`ACDR_SAMPLE_W-1:0] y;
		logic [`ACDR_SAMPLE_W-1:0] x;
	} acdr_sample_type;

	// One three-axis 8-bit high-pass delta set.
	typedef struct packed {
		logic [7:0] z;
		logic [7:0] y;
		logic [7:0] x;
	} acdr_delta_type;

	// Data status byte, laid out exactly as it is read.
	typedef struct packed {
		logic       all_axes_overwrite_flag;
		logic [2:0] overwrite_flag;
		logic       all_axes_ready_flag;
		logic [2:0] ready_flag;
	} acdr_status_type;

endpackage

`default_nettype wire

// ===== acdr_output_regs.sv
// Read-only output data register bank of a three-axis sensor: data status,
// 8-bit and 12-bit sample registers, buffer head redirection, delta registers.
// Assumes a serial slave front end that loads the register pointer, requests
// one byte per host read and reports stop conditions, all on sys_clk_i.
//
// Functional notes
// - Buffer output off: all three status aliases read the live data status.
// - Buffer output on: first two aliases read buffer status; third reads delta status.
// - Status byte: overwrite all/Z/Y/X in bits 7..4, ready all/Z/Y/X in 3..0.
// - Combined overwrite sets on unread set replaced; clears after all active high bytes read.
// - Axis overwrite sets when unread sample replaced; clears on its high byte read.
// - Combined ready sets on new enabled sample; clears after all enabled high bytes read.
// - Axis ready sets on new sample; clears on its high byte read.
// - Axis flags are generated only while that axis flag enable is one.
// - Combined flags are generated only while all three axis enables are one.
// - Samples are 12-bit; high byte holds bits 11..4, low byte bits 3..0.
// - Status then X, Y, Z high bytes sit at consecutive addresses for 4-byte bursts.
// - Status then X, Y, Z low/high pairs sit consecutively for 7-byte bursts.
// - Buffer output on: sample registers present the buffer head, 8- and 12-bit.
// - Buffer 8-bit reads at the X high byte address, 12-bit at X low address.
// - Buffer output on: other sample data addresses read zero.
// - Delta registers hold 8-bit high-pass data, updated whatever the buffer setting.
// - High-pass cutoff comes from the cutoff configuration register.
// - All status flags come out of reset cleared.
// - Auto-increment only during bursts; the pointer is discarded on stop.
// - Status and sample registers reset on standby to active transition.
// - Each buffer byte read returns the next byte of the oldest sample; reading its last byte consumes it.
`timescale 1ns/1ps
`default_nettype none

module acdr_output_regs
	import acdr_pkg::*;
#(
	parameter int FIFO_DEPTH = `ACDR_FIFO_DEPTH,
	parameter int FIFO_CNT_W = `ACDR_FIFO_CNT_W
)
(
	// Clock and reset.
	input  wire logic                  sys_clk_i,
	input  wire logic                  arst_n_i,
	// Configuration from the surrounding register file.
	input  wire logic                  buffer_output_enable_i,
	input  wire logic [2:0]            flag_gen_enable_i,
	input  wire logic [7:0]            hp_cutoff_cfg_i,
	input  wire logic                  device_active_i,
	// Real-time sample and delta streams.
	input  wire logic                  sample_valid_i,
	input  wire acdr_sample_type       sample_i,
	input  wire logic                  delta_valid_i,
	input  wire acdr_delta_type        delta_i,
	input  wire logic [7:0]            delta_status_i,
	// Sample buffer head.
	input  wire logic [7:0]            buffer_status_i,
	input  wire logic [FIFO_CNT_W-1:0] buffer_count_i,
	input  wire acdr_sample_type       buffer_head_i,
	output logic                       buffer_pop_o,
	// Register read port from the serial slave.
	input  wire logic                  addr_load_i,
	input  wire logic [7:0]            addr_i,
	input  wire logic                  rd_req_i,
	input  wire logic                  stop_i,
	output logic [7:0]                 rd_data_o,
	output logic                       rd_valid_o,
	// Filter setting and live status.
	output logic [7:0]                 hp_cutoff_o,
	output acdr_status_type            status_o
);

	// -------------------------------------------------------------------------
	// Helper functions
	// -------------------------------------------------------------------------

	// High byte of a 12-bit sample.
	function automatic logic [7:0] high_byte(input logic [`ACDR_SAMPLE_W-1:0] v);
		high_byte = v[`ACDR_HI_MSB:`ACDR_HI_LSB];
	endfunction

	// Low byte of a 12-bit sample, upper nibble zero.
	function automatic logic [7:0] low_byte(input logic [`ACDR_SAMPLE_W-1:0] v);
		low_byte = {`ACDR_ZERO_NIBBLE, v[`ACDR_LO_MSB:0]};
	endfunction

	// Auto-increment successor of a register address.
	function automatic logic [7:0] next_addr(input logic [7:0] a, input logic fde);
		unique case (a)
			`ACDR_ADDR_X_HI8:   next_addr = fde ? `ACDR_ADDR_X_HI8 : `ACDR_ADDR_Y_HI8;
			`ACDR_ADDR_Z_HI8:   next_addr = `ACDR_ADDR_STATUS_A;
			`ACDR_ADDR_X_LO:    next_addr = fde ? `ACDR_ADDR_X_LO : `ACDR_ADDR_X_HI12;
			`ACDR_ADDR_Z_HI12:  next_addr = `ACDR_ADDR_STATUS_B;
			`ACDR_ADDR_Z_DELTA: next_addr = `ACDR_ADDR_STATUS_C;
			default:            next_addr = a + `ACDR_ADDR_STEP;
		endcase
	endfunction

	// -------------------------------------------------------------------------
	// Storage and decoded events
	// -------------------------------------------------------------------------
	logic                  active_prev_reg;
	acdr_sample_type       sample_reg;
	acdr_delta_type        delta_reg;
	acdr_status_type       status_reg;
	acdr_status_type       status_next;
	logic [2:0]            hi_read_reg;
	logic [2:0]            hi_read_next;
	logic [7:0]            addr_reg;
	logic [2:0]            byte_idx_reg;
	logic [7:0]            rd_data_reg;
	logic                  rd_valid_reg;
	logic                  pop_reg;
	logic [7:0]            cutoff_reg;
	logic                  go_active;
	logic                  fde;
	logic [2:0]            new_axis;
	logic                  new_set;
	logic [2:0]            hi_hit;
	logic                  all_done;
	logic                  buf_8bit_rd;
	logic                  buf_12bit_rd;
	logic                  buf_has_data;
	logic                  buf_last;
	logic [7:0]            rd_value;
	logic [7:0]            buf_byte;

	// Standby to active edge and data-event qualifiers.
	assign go_active   = device_active_i & ~active_prev_reg;
	assign fde         = buffer_output_enable_i;
	assign new_axis    = {3{sample_valid_i}} & flag_gen_enable_i;
	assign new_set     = sample_valid_i & (&flag_gen_enable_i);

	// High byte reads of the live registers clear their axis flags.
	assign hi_hit[0] = rd_req_i & ~fde & ((addr_reg == `ACDR_ADDR_X_HI8) | (addr_reg == `ACDR_ADDR_X_HI12));
	assign hi_hit[1] = rd_req_i & ~fde & ((addr_reg == `ACDR_ADDR_Y_HI8) | (addr_reg == `ACDR_ADDR_Y_HI12));
	assign hi_hit[2] = rd_req_i & ~fde & ((addr_reg == `ACDR_ADDR_Z_HI8) | (addr_reg == `ACDR_ADDR_Z_HI12));

	// Every enabled axis has had its high byte read since the last sample.
	assign all_done = &((hi_read_reg | hi_hit) | ~flag_gen_enable_i);

	// Buffer reads go through the X addresses only.
	assign buf_8bit_rd  = rd_req_i & fde & (addr_reg == `ACDR_ADDR_X_HI8);
	assign buf_12bit_rd = rd_req_i & fde & (addr_reg == `ACDR_ADDR_X_LO);
	assign buf_has_data = (buffer_count_i != '0);
	assign buf_last     = (byte_idx_reg + 3'h1 >= (buf_12bit_rd ? `ACDR_BYTES_PER_12BIT : `ACDR_BYTES_PER_8BIT));

	// -------------------------------------------------------------------------
	// Standby to active edge detector
	// -------------------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			active_prev_reg <= 1'b1; // Seen as active, so release gives no false edge.
		else
			active_prev_reg <= device_active_i;
	end

	// -------------------------------------------------------------------------
	// Real-time sample registers
	// -------------------------------------------------------------------------
	// A new sample replaces the held one in the cycle it is offered.
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			sample_reg <= '0;
		else if (go_active)
			sample_reg <= '0;
		else if (sample_valid_i)
			sample_reg <= sample_i;
	end

	// -------------------------------------------------------------------------
	// Delta registers and filter setting
	// -------------------------------------------------------------------------
	// Deltas follow the filter regardless of the buffer output setting.
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			delta_reg <= '0;
		else if (delta_valid_i)
			delta_reg <= delta_i;
	end

	// The cutoff choice is handed to the filter from a flop.
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			cutoff_reg <= `ACDR_ZERO_BYTE;
		else
			cutoff_reg <= hp_cutoff_cfg_i;
	end

	// -------------------------------------------------------------------------
	// Status flags
	// -------------------------------------------------------------------------
	// Set wins over clear, so a sample landing on a clearing read is kept.
	always_comb
	begin
		status_next  = status_reg;
		hi_read_next = sample_valid_i ? 3'h0 : (hi_read_reg | hi_hit);
		for (int i = 0; i < 3; i++)
		begin
			if (hi_hit[i])
			begin
				status_next.ready_flag[i]     = 1'b0;
				status_next.overwrite_flag[i] = 1'b0;
			end
			if (new_axis[i])
			begin
				status_next.overwrite_flag[i] = status_reg.ready_flag[i] & ~hi_hit[i];
				status_next.ready_flag[i]     = 1'b1;
			end
		end
		if (all_done)
		begin
			status_next.all_axes_ready_flag     = 1'b0;
			status_next.all_axes_overwrite_flag = 1'b0;
		end
		if (new_set)
		begin
			status_next.all_axes_overwrite_flag = status_reg.all_axes_ready_flag & ~all_done;
			status_next.all_axes_ready_flag     = 1'b1;
		end
	end

	// Flag storage, cleared at reset and on entry to active operation.
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			status_reg  <= '0;
			hi_read_reg <= 3'h0;
		end
		else if (go_active)
		begin
			status_reg  <= '0;
			hi_read_reg <= 3'h0;
		end
		else
		begin
			status_reg  <= status_next;
			hi_read_reg <= hi_read_next;
		end
	end

	// -------------------------------------------------------------------------
	// Buffer head byte selection
	// -------------------------------------------------------------------------
	// Oldest sample byte by position within the sample; empty buffer reads zero.
	always_comb
	begin
		buf_byte = `ACDR_ZERO_BYTE;
		if (buf_has_data & buf_12bit_rd)
		begin
			unique case (byte_idx_reg)
				3'h0:    buf_byte = low_byte(buffer_head_i.x);
				3'h1:    buf_byte = high_byte(buffer_head_i.x);
				3'h2:    buf_byte = low_byte(buffer_head_i.y);
				3'h3:    buf_byte = high_byte(buffer_head_i.y);
				3'h4:    buf_byte = low_byte(buffer_head_i.z);
				3'h5:    buf_byte = high_byte(buffer_head_i.z);
				default: buf_byte = `ACDR_ZERO_BYTE;
			endcase
		end
		else if (buf_has_data)
		begin
			unique case (byte_idx_reg)
				3'h0:    buf_byte = high_byte(buffer_head_i.x);
				3'h1:    buf_byte = high_byte(buffer_head_i.y);
				3'h2:    buf_byte = high_byte(buffer_head_i.z);
				default: buf_byte = `ACDR_ZERO_BYTE;
			endcase
		end
	end

	// -------------------------------------------------------------------------
	// Read data multiplexer
	// -------------------------------------------------------------------------
	// Status aliases and sample addresses change meaning with buffer output.
	always_comb
	begin
		rd_value = `ACDR_ZERO_BYTE;
		unique case (addr_reg)
			`ACDR_ADDR_STATUS_A,
			`ACDR_ADDR_STATUS_B: rd_value = fde ? buffer_status_i : status_reg;
			`ACDR_ADDR_STATUS_C: rd_value = fde ? delta_status_i : status_reg;
			`ACDR_ADDR_X_HI8:    rd_value = fde ? buf_byte : high_byte(sample_reg.x);
			`ACDR_ADDR_Y_HI8:    rd_value = fde ? `ACDR_ZERO_BYTE : high_byte(sample_reg.y);
			`ACDR_ADDR_Z_HI8:    rd_value = fde ? `ACDR_ZERO_BYTE : high_byte(sample_reg.z);
			`ACDR_ADDR_X_LO:     rd_value = fde ? buf_byte : low_byte(sample_reg.x);
			`ACDR_ADDR_X_HI12:   rd_value = fde ? `ACDR_ZERO_BYTE : high_byte(sample_reg.x);
			`ACDR_ADDR_Y_LO:     rd_value = fde ? `ACDR_ZERO_BYTE : low_byte(sample_reg.y);
			`ACDR_ADDR_Y_HI12:   rd_value = fde ? `ACDR_ZERO_BYTE : high_byte(sample_reg.y);
			`ACDR_ADDR_Z_LO:     rd_value = fde ? `ACDR_ZERO_BYTE : low_byte(sample_reg.z);
			`ACDR_ADDR_Z_HI12:   rd_value = fde ? `ACDR_ZERO_BYTE : high_byte(sample_reg.z);
			`ACDR_ADDR_X_DELTA:  rd_value = delta_reg.x;
			`ACDR_ADDR_Y_DELTA:  rd_value = delta_reg.y;
			`ACDR_ADDR_Z_DELTA:  rd_value = delta_reg.z;
			default:             rd_value = `ACDR_ZERO_BYTE;
		endcase
	end

	// -------------------------------------------------------------------------
	// Register pointer
	// -------------------------------------------------------------------------
	// Loaded by the address phase, stepped per burst byte, dropped on stop.
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			addr_reg <= `ACDR_RST_ADDR;
		else if (stop_i)
			addr_reg <= `ACDR_RST_ADDR;
		else if (addr_load_i)
			addr_reg <= addr_i;
		else if (rd_req_i)
			addr_reg <= next_addr(addr_reg, fde);
	end

	// -------------------------------------------------------------------------
	// Buffer byte position and consumption
	// -------------------------------------------------------------------------
	// A sample leaves the buffer once its last byte has been read.
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			byte_idx_reg <= 3'h0;
			pop_reg      <= 1'b0;
		end
		else
		begin
			pop_reg <= 1'b0;
			if (stop_i | addr_load_i)
				byte_idx_reg <= 3'h0;
			else if ((buf_8bit_rd | buf_12bit_rd) & buf_has_data)
			begin
				byte_idx_reg <= buf_last ? 3'h0 : byte_idx_reg + 3'h1;
				pop_reg      <= buf_last;
			end
		end
	end

	// -------------------------------------------------------------------------
	// Read answer
	// -------------------------------------------------------------------------
	// One byte answers each request in the following cycle.
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rd_data_reg  <= `ACDR_ZERO_BYTE;
			rd_valid_reg <= 1'b0;
		end
		else
		begin
			rd_valid_reg <= rd_req_i;
			if (rd_req_i)
				rd_data_reg <= rd_value;
		end
	end

	// Every output comes straight from its flop.
	assign rd_data_o    = rd_data_reg;
	assign rd_valid_o   = rd_valid_reg;
	assign buffer_pop_o = pop_reg;
	assign hp_cutoff_o  = cutoff_reg;
	assign status_o     = status_reg;

endmodule

`default_nettype wire

// ===== acdr_output_regs_chk.sv
// Assertions on the ports of the output data register bank.
// Assumes a bind from the bench onto acdr_output_regs.
`timescale 1ns/1ps
`default_nettype none

module acdr_output_regs_chk
	import acdr_pkg::*;
(
	// Clock and reset.
	input wire logic            sys_clk_i,
	input wire logic            arst_n_i,
	// Inputs watched.
	input wire logic            buffer_output_enable_i,
	input wire logic [2:0]      flag_gen_enable_i,
	input wire logic [7:0]      hp_cutoff_cfg_i,
	input wire logic            device_active_i,
	input wire logic            sample_valid_i,
	input wire logic            rd_req_i,
	// Outputs watched.
	input wire logic            buffer_pop_o,
	input wire logic            rd_valid_o,
	input wire logic [7:0]      hp_cutoff_o,
	input wire acdr_status_type status_o
);
	// -------------------------------------------------------------------------
	// Properties
	// -------------------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);

	a_answer_one_cycle: assert property (rd_req_i |=> rd_valid_o)
		else $error("read answer missing after request");
	a_no_stray_answer: assert property (!rd_req_i |=> !rd_valid_o)
		else $error("read answer without request");
	a_ready_on_sample: assert property (sample_valid_i && flag_gen_enable_i[0] |=> status_o.ready_flag[0])
		else $error("x ready not set by sample");
	a_overwrite_on_unread: assert property (sample_valid_i && flag_gen_enable_i[2] && status_o.ready_flag[2]
		|=> status_o.overwrite_flag[2])
		else $error("z overwrite not set");
	a_all_ready_set: assert property (sample_valid_i && (&flag_gen_enable_i) |=> status_o.all_axes_ready_flag)
		else $error("combined ready not set");
	a_disabled_quiet: assert property (!flag_gen_enable_i[1] && !status_o.ready_flag[1] |=> !status_o.ready_flag[1])
		else $error("y ready raised while disabled");
	a_combined_gated: assert property (!(&flag_gen_enable_i) && !status_o.all_axes_ready_flag
		|=> !status_o.all_axes_ready_flag)
		else $error("combined ready raised while an axis disabled");
	a_ready_has_cause: assert property ($rose(status_o.ready_flag[0]) |-> $past(sample_valid_i))
		else $error("x ready rose without sample");
	a_activation_clears: assert property ($rose(device_active_i) |-> ##[1:2] status_o == 8'h00)
		else $error("status not cleared on activation");
	a_pop_after_read: assert property (buffer_pop_o |-> $past(buffer_output_enable_i) &&
		($past(rd_req_i) || $past(rd_req_i, 2)))
		else $error("pop without buffered read");
	a_cutoff_follows: assert property ($stable(hp_cutoff_cfg_i)[*2] |-> hp_cutoff_o == hp_cutoff_cfg_i)
		else $error("cutoff output differs from setting");
endmodule

`default_nettype wire

// ===== acdr_host_model.sv
// Host front end model that reads the register bank byte by byte.
// Assumes the bench calls its task; requests change at the falling edge.
`timescale 1ns/1ps
`default_nettype none

module acdr_host_model
(
	// Clock.
	input  wire logic       sys_clk_i,
	// Requests.
	output logic            addr_load_o,
	output logic [7:0]      addr_o,
	output logic            rd_req_o,
	output logic            stop_o,
	// Answers.
	input  wire logic [7:0] rd_data_i,
	input  wire logic       rd_valid_i
);
	// -------------------------------------------------------------------------
	// Read transaction
	// -------------------------------------------------------------------------
	logic [7:0] got[$];
	int         stray;

	// Idle levels from time zero.
	initial
	begin
		addr_load_o = 1'b0;
		addr_o = 8'hA5;
		rd_req_o = 1'b0;
		stop_o = 1'b0;
		stray = 0;
	end

	// Reads n bytes, with gap idle cycles between requests, then ends with a stop.
	task automatic burst(input logic ld, input logic [7:0] a, input int n, input int gap);
		int p;
		got.delete();
		stray = 0;
		p = gap + 1;
		if (ld)
		begin
			@(negedge sys_clk_i);
			addr_load_o = 1'b1;
			addr_o = a;
		end
		for (int t = 0; t <= (n - 1) * p + 2; t++)
		begin
			@(negedge sys_clk_i);
			addr_load_o = 1'b0;
			addr_o = ~a;
			if (t >= 1 && (t - 1) % p == 0 && (t - 1) / p < n)
				got.push_back(rd_valid_i === 1'b1 ? rd_data_i : 8'hXX);
			else if (rd_valid_i !== 1'b0)
				stray++;
			rd_req_o = (t % p == 0 && t / p < n);
		end
		@(negedge sys_clk_i);
		stop_o = 1'b1;
		@(negedge sys_clk_i);
		stop_o = 1'b0;
	endtask
endmodule

`default_nettype wire

// ===== acdr_output_regs_bench.sv
// Self-checking bench of the output data register bank.
// Assumes the package, the design, the checker and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module acdr_output_regs_bench
	import acdr_pkg::*;
;
	// -------------------------------------------------------------------------
	// Signals and instances
	// -------------------------------------------------------------------------
	logic sys_clk_i, arst_n_i, buffer_output_enable_i, device_active_i, sample_valid_i, delta_valid_i;
	logic [2:0] flag_gen_enable_i;
	logic [7:0] hp_cutoff_cfg_i, delta_status_i, buffer_status_i, addr_i, rd_data_o, hp_cutoff_o;
	logic [5:0] buffer_count_i;
	logic buffer_pop_o, addr_load_i, rd_req_i, stop_i, rd_valid_o;
	acdr_sample_type sample_i, buffer_head_i;
	acdr_delta_type delta_i;
	acdr_status_type status_o;
	int mismatches, comparisons, pops;

	acdr_output_regs DUT (.sys_clk_i, .arst_n_i, .buffer_output_enable_i, .flag_gen_enable_i, .hp_cutoff_cfg_i,
		.device_active_i, .sample_valid_i, .sample_i, .delta_valid_i, .delta_i, .delta_status_i, .buffer_status_i,
		.buffer_count_i, .buffer_head_i, .buffer_pop_o, .addr_load_i, .addr_i, .rd_req_i, .stop_i, .rd_data_o,
		.rd_valid_o, .hp_cutoff_o, .status_o);
	acdr_host_model host (.sys_clk_i, .addr_load_o(addr_load_i), .addr_o(addr_i), .rd_req_o(rd_req_i),
		.stop_o(stop_i), .rd_data_i(rd_data_o), .rd_valid_i(rd_valid_o));

	// Clock and pop counter.
	always #5 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i)
		if (buffer_pop_o === 1'b1)
			pops++;

	// -------------------------------------------------------------------------
	// Compare and drive tasks
	// -------------------------------------------------------------------------
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Compares the bytes of the last burst, their count and any stray answers.
	task automatic cmp_burst(input logic [7:0] e[$]);
		cmp8(8'(host.got.size()), 8'(e.size()));
		foreach (e[i])
			cmp8(host.got[i], e[i]);
		cmp8(8'(host.stray), 8'h00);
	endtask

	task automatic push(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
		@(negedge sys_clk_i);
		sample_i = {z, y, x};
		sample_valid_i = 1'b1;
		@(negedge sys_clk_i);
		sample_valid_i = 1'b0;
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// -------------------------------------------------------------------------
	// Scenarios
	// -------------------------------------------------------------------------
	task automatic t_realtime();
		cmp8(status_o, 8'h00);
		@(negedge sys_clk_i);
		cmp8(hp_cutoff_o, 8'h3C);
		push(12'hA5C, 12'h123, 12'h7FF);
		cmp8(status_o, 8'h0F);
		push(12'h801, 12'h3E4, 12'hF00);
		cmp8(status_o, 8'hFF);
		host.burst(1'b1, 8'h04, 7, 0);
		cmp_burst('{8'hFF, 8'h01, 8'h80, 8'h04, 8'h3E, 8'h00, 8'hF0});
		cmp8(status_o, 8'h00);
		push(12'hA5C, 12'h123, 12'h7FF);
		host.burst(1'b1, 8'h00, 5, 1);
		cmp_burst('{8'h0F, 8'hA5, 8'h12, 8'h7F, 8'h00});
	endtask

	task automatic t_alias();
		logic [7:0] al[3] = '{8'h00, 8'h04, 8'h0B};
		logic [7:0] hi[3] = '{8'hA5, 8'h12, 8'h7F};
		logic [7:0] st[3] = '{8'h0E, 8'h0C, 8'h00};
		push(12'hA5C, 12'h123, 12'h7FF);
		for (int i = 0; i < 3; i++)
		begin
			host.burst(1'b1, al[i], 1, 0);
			cmp_burst('{8'h0F});
		end
		for (int i = 0; i < 3; i++)
		begin
			host.burst(1'b1, 8'(i + 1), 1, 0);
			cmp_burst('{hi[i]});
			cmp8(status_o, st[i]);
		end
	endtask

	task automatic t_enables();
		@(negedge sys_clk_i);
		flag_gen_enable_i = 3'b001;
		push(12'hA5C, 12'h123, 12'h7FF);
		cmp8(status_o, 8'h01);
		push(12'hA5C, 12'h123, 12'h7FF);
		cmp8(status_o, 8'h11);
		host.burst(1'b1, 8'h01, 1, 0);
		cmp8(status_o, 8'h00);
		flag_gen_enable_i = 3'b111;
	endtask

	task automatic t_buffer();
		logic [7:0] al[3] = '{8'h00, 8'h04, 8'h0B};
		logic [7:0] ex[3] = '{8'h82, 8'h82, 8'h44};
		logic [7:0] zr[7] = '{8'h02, 8'h03, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A};
		@(negedge sys_clk_i);
		buffer_output_enable_i = 1'b1;
		buffer_head_i = {12'h7FF, 12'h123, 12'hA5C};
		foreach (al[i])
		begin
			host.burst(1'b1, al[i], 1, 0);
			cmp_burst('{ex[i]});
		end
		foreach (zr[i])
		begin
			host.burst(1'b1, zr[i], 1, 0);
			cmp_burst('{8'h00});
		end
		host.burst(1'b1, 8'h01, 3, 0);
		cmp_burst('{8'hA5, 8'h12, 8'h7F});
		cmp8(8'(pops), 8'h01);
		buffer_head_i = {12'hF00, 12'h3E4, 12'h801};
		buffer_count_i = 6'h01;
		host.burst(1'b1, 8'h05, 6, 1);
		cmp_burst('{8'h01, 8'h80, 8'h04, 8'h3E, 8'h00, 8'hF0});
		cmp8(8'(pops), 8'h02);
		delta_i = {8'h9C, 8'h7F, 8'h80};
		delta_valid_i = 1'b1;
		@(negedge sys_clk_i);
		delta_valid_i = 1'b0;
		host.burst(1'b1, 8'h0C, 3, 0);
		cmp_burst('{8'h80, 8'h7F, 8'h9C});
		buffer_output_enable_i = 1'b0;
	endtask

	task automatic t_stop_activate();
		push(12'hA5C, 12'h123, 12'h7FF);
		host.burst(1'b1, 8'h07, 1, 0);
		cmp_burst('{8'h03});
		host.burst(1'b0, 8'h00, 1, 0);
		cmp_burst('{8'h0F});
		device_active_i = 1'b0;
		repeat (2) @(negedge sys_clk_i);
		device_active_i = 1'b1;
		repeat (3) @(negedge sys_clk_i);
		cmp8(status_o, 8'h00);
		host.burst(1'b1, 8'h06, 1, 0);
		cmp_burst('{8'h00});
	endtask

	// Main sequence: time-zero values, reset for three cycles, then the scenarios.
	initial
	begin
		{sys_clk_i, arst_n_i, buffer_output_enable_i, sample_valid_i, delta_valid_i} = 5'h00;
		{mismatches, comparisons, pops} = {32'h0, 32'h0, 32'h0};
		device_active_i = 1'b1;
		flag_gen_enable_i = 3'b111;
		hp_cutoff_cfg_i = 8'h3C;
		{delta_status_i, buffer_status_i, buffer_count_i} = {8'h44, 8'h82, 6'h02};
		{sample_i, buffer_head_i, delta_i} = '0;
		repeat (3) @(negedge sys_clk_i);
		arst_n_i = 1'b1;
		t_realtime();
		t_alias();
		t_enables();
		t_buffer();
		t_stop_activate();
		close_out();
	end

	// Watchdog well beyond the few hundred cycles the scenarios take.
	initial
	begin
		repeat (5000) @(posedge sys_clk_i);
		mismatches++;
		close_out();
	end
endmodule

bind acdr_output_regs acdr_output_regs_chk chk (.sys_clk_i, .arst_n_i, .buffer_output_enable_i,
	.flag_gen_enable_i, .hp_cutoff_cfg_i, .device_active_i, .sample_valid_i, .rd_req_i, .buffer_pop_o,
	.rd_valid_o, .hp_cutoff_o, .status_o);

`default_nettype wire
